// ### src/hrxf_top.sv
// Receive packet FIFO readout with APB register slave and interrupt
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "hrxf_cfg.svh"

module hrxf_top #(
  parameter int DEPTH  = `HRXF_DEPTH,
  parameter int ADDR_W = `HRXF_ADDR_W
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  // APB slave
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Byte stream from the receive framer, first received bit in bit 0
  input  wire logic                    rxWrEn,
  input  wire logic [`HRXF_BYTE_W-1:0] rxWrByte,
  input  wire logic [`HRXF_POS_W-1:0]  rxWrPos,
  // Interrupt request, active high level
  output logic                         irq
);
  localparam int PW    = $clog2(DEPTH);
  localparam int ENT_W = `HRXF_BYTE_W + `HRXF_POS_W;

  // ========================================================================
  // Elaboration checks
  if (ADDR_W < 16) begin : g_bad_addr
    $error("hrxf_top: ADDR_W must reach the register indices");
  end
  if (PW + 1 < `HRXF_BYTE_W) begin : g_bad_depth
    $error("hrxf_top: DEPTH must hold the highest available level");
  end

  // ========================================================================
  // Helper functions
  function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                  input logic [13:0]       idx);
    regHit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic logic [`HRXF_BYTE_W-1:0] bitRev(
      input logic [`HRXF_BYTE_W-1:0] b);
    logic [`HRXF_BYTE_W-1:0] r;
    r = '0;
    for (int i = 0; i < `HRXF_BYTE_W; i++) begin
      r[i] = b[`HRXF_BYTE_W-1-i];
    end
    bitRev = r;
  endfunction

  function automatic logic isEnd(input logic [`HRXF_POS_W-1:0] p);
    isEnd = p[`HRXF_POS_W-1];
  endfunction

  // ========================================================================
  // Register state
  logic [`HRXF_CTRL1_W-1:0] ctrl1Q;
  logic [`HRXF_CTRL2_W-1:0] ctrl2Q;
  logic [`HRXF_FLAG_W-1:0]  irqEnQ;
  logic                     dropQ;
  logic                     fullPrevQ;
  logic                     availPrevQ;
  logic                     preadyQ;
  logic                     pslverrQ;
  logic [31:0]              prdataQ;

  // ========================================================================
  // APB phase decode: the slave answers one cycle into the access phase
  wire accessWait = psel & penable & ~preadyQ;
  wire xferDone   = psel & penable & preadyQ;
  wire wrDone     = xferDone & pwrite & pstrb[0];
  wire rdDone     = xferDone & ~pwrite;

  // Address decode
  wire hitCtrl1   = regHit(paddr, `HRXF_IDX_CTRL1);
  wire hitCtrl2   = regHit(paddr, `HRXF_IDX_CTRL2);
  wire hitLive    = regHit(paddr, `HRXF_IDX_LIVE);
  wire hitLatched = regHit(paddr, `HRXF_IDX_LATCHED);
  wire hitIrqEn   = regHit(paddr, `HRXF_IDX_IRQ_EN);
  wire hitEntStat = regHit(paddr, `HRXF_IDX_ENT_STAT);
  wire hitEntByte = regHit(paddr, `HRXF_IDX_ENT_BYTE);
  wire mapped     = hitCtrl1 | hitCtrl2 | hitLive | hitLatched
                  | hitIrqEn | hitEntStat | hitEntByte;

  // ========================================================================
  // Incoming byte: optional inversion, then optional reordering
  wire                      fifoRst  = ctrl1Q[`HRXF_C1_FIFO_RST];
  wire [`HRXF_BYTE_W-1:0]   inByte   = ctrl1Q[`HRXF_C1_INVERT] ? ~rxWrByte : rxWrByte;
  wire [`HRXF_BYTE_W-1:0]   ordByte  = ctrl1Q[`HRXF_C1_REORDER] ? bitRev(inByte)
                                                              : inByte;
  wire                      startIn  = (rxWrPos == hrxf_pkg::POS_START);
  wire                      rsvdIn   = (rxWrPos == hrxf_pkg::POS_RSVD_A)
                                     | (rxWrPos == hrxf_pkg::POS_RSVD_B);

  // Reserved codes are never stored, so they can never be presented
  wire                      wrReady;
  wire                      wantWr   = rxWrEn & ~rsvdIn & ~fifoRst
                                     & (~dropQ | startIn);
  wire                      accept   = wantWr & wrReady;
  wire                      overflow = wantWr & ~wrReady;

  // ========================================================================
  // FIFO: byte plus position code per entry
  wire                      headValid;
  wire [ENT_W-1:0]          headEnt;
  wire [PW:0]               fillCount;
  wire                      popReq   = rdDone & hitEntByte;

  hrxf_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .flush   (fifoRst),
    .wrValid (accept),
    .wrReady (wrReady),
    .wrData  ({rxWrPos, ordByte}),
    .rdValid (headValid),
    .rdReady (popReq),
    .rdData  (headEnt),
    .count   (fillCount)
  );

  // ========================================================================
  // Live status: full, empty and level-based data available
  wire [PW:0] availLevel = (PW+1)'({ctrl2Q, `HRXF_GROUP_ZEROS});
  wire        fullLive   = ~wrReady;
  wire        emptyLive  = ~headValid;
  wire        availLive  = ~fifoRst & (fillCount >= availLevel);

  // Presented entry; the code is masked to zero while nothing is valid
  wire [`HRXF_POS_W-1:0]  headPos  = headValid ? headEnt[ENT_W-1:`HRXF_BYTE_W]
                                               : hrxf_pkg::POS_MIDDLE;
  wire [`HRXF_BYTE_W-1:0] headByte = headEnt[`HRXF_BYTE_W-1:0];

  // ========================================================================
  // Event pulses into the sticky flags
  logic [`HRXF_FLAG_W-1:0] events;
  wire  [`HRXF_FLAG_W-1:0] latched;

  always_comb begin
    events                  = `HRXF_FLAG_RST;
    events[`HRXF_F_START]   = accept & startIn;
    events[`HRXF_F_END]     = accept & isEnd(rxWrPos);
    events[`HRXF_F_FULL]    = fullLive & ~fullPrevQ;
    events[`HRXF_F_AVAIL]   = availLive & ~availPrevQ;
    events[`HRXF_F_OVFL]    = overflow;
  end

  // Enables of absent flags are stored as zero, so they never gate anything
  hrxf_irq #(
    .N (`HRXF_FLAG_W)
  ) u_irq (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .events  (events),
    .clrStb  (wrDone & hitLatched),
    .clrBits (pwdata[`HRXF_FLAG_W-1:0]),
    .enable  (irqEnQ),
    .latched (latched),
    .irq     (irq)
  );

  // ========================================================================
  // Read data selection; unused bits read as zero
  wire [`HRXF_BYTE_W-1:0] rdValue =
      hitCtrl1   ? `HRXF_BYTE_W'(ctrl1Q) :
      hitCtrl2   ? `HRXF_BYTE_W'(ctrl2Q) :
      hitLive    ? `HRXF_BYTE_W'({fullLive, emptyLive, availLive}) :
      hitLatched ? latched :
      hitIrqEn   ? irqEnQ :
      hitEntStat ? `HRXF_BYTE_W'({headPos, headValid}) :
      hitEntByte ? headByte :
                   '0;

  // ========================================================================
  // APB answer: pready, data and error all registered
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      preadyQ  <= 1'b0;
      pslverrQ <= 1'b0;
      prdataQ  <= '0;
    end else begin
      preadyQ  <= accessWait;
      pslverrQ <= accessWait & ~mapped;
      if (accessWait & ~pwrite) begin
        prdataQ <= 32'(rdValue);
      end
    end
  end

  assign pready  = preadyQ;
  assign pslverr = pslverrQ;
  assign prdata  = prdataQ;

  // ========================================================================
  // Software registers; read-only targets ignore writes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl1Q <= `HRXF_CTRL1_RST;
      ctrl2Q <= `HRXF_CTRL2_RST;
      irqEnQ <= `HRXF_FLAG_RST;
    end else if (wrDone) begin
      if (hitCtrl1) begin
        ctrl1Q <= pwdata[`HRXF_CTRL1_W-1:0];
      end
      if (hitCtrl2) begin
        ctrl2Q <= pwdata[`HRXF_CTRL2_W-1:0];
      end
      if (hitIrqEn) begin
        irqEnQ <= pwdata[`HRXF_FLAG_W-1:0] & `HRXF_FLAG_MASK;
      end
    end
  end

  // ========================================================================
  // After a FIFO reset, bytes are dropped until a packet start arrives,
  // so the host never sees the tail of a packet cut in half
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dropQ <= 1'b0;
    end else if (fifoRst) begin
      dropQ <= 1'b1;
    end else if (rxWrEn & startIn & wrReady) begin
      dropQ <= 1'b0;
    end
  end

  // Previous live levels for the rising-edge events; available idles high
  // after reset (level zero, count zero), so its history starts high too
  // and no false rise is latched on the first clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fullPrevQ  <= 1'b0;
      availPrevQ <= 1'b1;
    end else begin
      fullPrevQ  <= fullLive;
      availPrevQ <= availLive;
    end
  end

endmodule

// ### common/hrxf_cfg.svh
// Register map, field positions and reset values of the receive FIFO readout
`ifndef HRXF_CFG_SVH
`define HRXF_CFG_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define HRXF_IDX_CTRL1      14'h1510
`define HRXF_IDX_CTRL2      14'h1511
`define HRXF_IDX_LIVE       14'h1514
`define HRXF_IDX_LATCHED    14'h1516
`define HRXF_IDX_IRQ_EN     14'h1518
`define HRXF_IDX_ENT_STAT   14'h151c
`define HRXF_IDX_ENT_BYTE   14'h151d

// ==========================================================================
// Control register 1 fields
`define HRXF_CTRL1_W        4
`define HRXF_CTRL1_RST      4'h0
`define HRXF_C1_FIFO_RST    0
`define HRXF_C1_FCS_DIS     1
`define HRXF_C1_INVERT      2
`define HRXF_C1_REORDER     3

// Control register 2: available level in groups of eight bytes
`define HRXF_CTRL2_W        5
`define HRXF_CTRL2_RST      5'h00
`define HRXF_GROUP_ZEROS    3'h0

// ==========================================================================
// Latched flags and their enables share one layout
`define HRXF_FLAG_W         8
`define HRXF_FLAG_RST       8'h00
`define HRXF_FLAG_MASK      8'h9d
`define HRXF_F_AVAIL        0
`define HRXF_F_FULL         2
`define HRXF_F_START        3
`define HRXF_F_END          4
`define HRXF_F_OVFL         7

// ==========================================================================
// Data path
`define HRXF_BYTE_W         8
`define HRXF_POS_W          3
`define HRXF_DEPTH          256
`define HRXF_ADDR_W         16

`endif

// ### common/hrxf_pkg.sv
// Types shared by the receive FIFO readout modules
package hrxf_pkg;

  // ========================================================================
  // Packet position code stored with every byte
  typedef enum logic [2:0] {
    POS_MIDDLE    = 3'h0,
    POS_START     = 3'h1,
    POS_RSVD_A    = 3'h2,
    POS_RSVD_B    = 3'h3,
    POS_END_GOOD  = 3'h4,
    POS_END_FCS   = 3'h5,
    POS_END_ODD   = 3'h6,
    POS_END_ABORT = 3'h7
  } hrxf_pos_t;

endpackage

// ### src/hrxf_fifo.sv
// Flip-flop FIFO holding one byte and its position code per entry
`timescale 1ns/1ps
`include "hrxf_cfg.svh"

module hrxf_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = `HRXF_DEPTH
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  // Synchronous flush
  input  wire logic                     flush,
  // Fill side
  input  wire logic                     wrValid,
  output logic                          wrReady,
  input  wire logic [WIDTH-1:0]         wrData,
  // Drain side
  output logic                          rdValid,
  input  wire logic                     rdReady,
  output logic [WIDTH-1:0]              rdData,
  // Fill level
  output logic [$clog2(DEPTH):0]        count
);
  localparam int PW = $clog2(DEPTH);

  // ========================================================================
  // Elaboration check: pointers wrap naturally only on a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("hrxf_fifo: DEPTH must be a power of two of at least 2");
  end

  // ========================================================================
  // Storage and pointers
  logic [WIDTH-1:0] memQ [DEPTH];
  logic [PW-1:0]    wrPtrQ;
  logic [PW-1:0]    rdPtrQ;
  logic [PW:0]      countQ;
  wire              doWr = wrValid & wrReady & ~flush;
  wire              doRd = rdValid & rdReady & ~flush;

  // Full and empty come straight from the fill count
  assign wrReady = (countQ != (PW+1)'(DEPTH));
  assign rdValid = (countQ != '0);
  assign rdData  = memQ[rdPtrQ];
  assign count   = countQ;

  // Pointer and count update; flush empties in one cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      countQ <= '0;
    end else if (flush) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      countQ <= '0;
    end else begin
      wrPtrQ <= wrPtrQ + PW'(doWr);
      rdPtrQ <= rdPtrQ + PW'(doRd);
      countQ <= countQ + (PW+1)'(doWr) - (PW+1)'(doRd);
    end
  end

  // Data array has no reset; contents are meaningless while empty
  always_ff @(posedge clk_sys) begin
    if (doWr) begin
      memQ[wrPtrQ] <= wrData;
    end
  end

endmodule

// ### src/hrxf_irq.sv
// Sticky event flags, enable gating and the registered interrupt line
`timescale 1ns/1ps
`include "hrxf_cfg.svh"

module hrxf_irq #(
  parameter int N = `HRXF_FLAG_W
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  // Hardware events, one-cycle pulses
  input  wire logic [N-1:0] events,
  // Software write-one-to-clear
  input  wire logic         clrStb,
  input  wire logic [N-1:0] clrBits,
  // Enables and results
  input  wire logic [N-1:0] enable,
  output logic [N-1:0]      latched,
  output logic              irq
);
  if (N < 1) begin : g_bad_n
    $error("hrxf_irq: N must be at least 1");
  end

  logic [N-1:0] latQ;
  logic         irqQ;

  // A set in the same cycle as its clear wins, so no event is lost
  wire [N-1:0] clrMask = clrStb ? clrBits : '0;
  wire [N-1:0] latD    = (latQ & ~clrMask) | events;

  // Flags hold until cleared; the line follows the next flag value
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      latQ <= '0;
      irqQ <= 1'b0;
    end else begin
      latQ <= latD;
      irqQ <= |(latD & enable);
    end
  end

  assign latched = latQ;
  assign irq     = irqQ;

endmodule

// ### dv/hrxf_top_asserts.sv
// Port-level checker for the receive FIFO readout
`timescale 1ns/1ps
`include "hrxf_cfg.svh"

module hrxf_top_asserts #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              reset_n,
  // APB
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Stream and interrupt
  input wire logic              rxWrEn,
  input wire logic              irq
);
  // ====
  // Decode, aligned words only
  wire [13:0] idx    = paddr[15:2];
  wire        alg    = paddr[1:0] == 2'b00;
  wire        isStat = alg && idx == `HRXF_IDX_ENT_STAT;
  wire        rdDone = pready && !pwrite;
  wire        mapped = idx inside {`HRXF_IDX_CTRL1, `HRXF_IDX_CTRL2, `HRXF_IDX_LIVE,
    `HRXF_IDX_LATCHED, `HRXF_IDX_IRQ_EN, `HRXF_IDX_ENT_STAT, `HRXF_IDX_ENT_BYTE};

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  a_ready_one_cyc: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_access_two_cyc: assert property (s_setup ##1 s_access |=> pready)
    else $error("access not two cycles");
  a_err_unmapped: assert property (pready && alg |-> pslverr == !mapped)
    else $error("slave error wrong");
  a_rdata_upper: assert property (rdDone |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_code_not_rsvd: assert property (rdDone && isStat |-> prdata[3:2] != 2'b01)
    else $error("reserved code read");
  a_empty_code_zero: assert property (rdDone && isStat && !prdata[0] |-> prdata[7:1] == 7'h0)
    else $error("empty status not zero");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(rxWrEn) || $past(rxWrEn, 2)
    || $past(rxWrEn, 3) || $past(pready) || $past(pready, 2) || $past(pready, 3))
    else $error("irq rose without cause");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(pready) || $past(pready, 2)
    || $past(pready, 3))
    else $error("irq fell without write");
endmodule

bind hrxf_top hrxf_top_asserts #(.ADDR_W(ADDR_W)) chk_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxWrEn(rxWrEn), .irq(irq));

// ### dv/hrxf_framer_model.sv
// Byte source standing in for the receive framer
`timescale 1ns/1ps

module hrxf_framer_model (
  // Clock
  input wire logic clk_sys,
  // Byte stream toward the FIFO
  output logic       rxWrEn,
  output logic [7:0] rxWrByte,
  output logic [2:0] rxWrPos
);
  // ====
  // Idle lines start at zero, then show the inverse of the last byte so stale data never looks valid
  initial begin
    rxWrEn   = 1'b0;
    rxWrByte = 8'h00;
    rxWrPos  = 3'h0;
  end

  // One strobe per byte, byte and code always together
  task automatic send(input logic [7:0] b, input logic [2:0] p);
    @(posedge clk_sys);
    rxWrEn   <= 1'b1;
    rxWrByte <= b;
    rxWrPos  <= p;
    @(posedge clk_sys);
    rxWrEn   <= 1'b0;
    rxWrByte <= ~b;
    rxWrPos  <= ~p;
  endtask
endmodule

// ### dv/tb_top.sv
// Register-level testbench of the receive FIFO readout
`timescale 1ns/1ps
`include "hrxf_cfg.svh"

module tb_top;
  // ====
  // Signals
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxWrEn;
  logic [7:0]  rxWrByte;
  logic [2:0]  rxWrPos;
  logic        irq;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;
  localparam logic [15:0] ACTL1 = {`HRXF_IDX_CTRL1, 2'b00};
  localparam logic [15:0] ACTL2 = {`HRXF_IDX_CTRL2, 2'b00};
  localparam logic [15:0] ALAT  = {`HRXF_IDX_LATCHED, 2'b00};
  localparam logic [15:0] AEN   = {`HRXF_IDX_IRQ_EN, 2'b00};
  localparam logic [15:0] ASTAT = {`HRXF_IDX_ENT_STAT, 2'b00};
  localparam logic [15:0] ABYTE = {`HRXF_IDX_ENT_BYTE, 2'b00};
  logic [7:0] eb [8] = '{8'ha5, 8'h5a, 8'hc3, 8'h01, 8'h80, 8'hff, 8'h22, 8'h44};
  logic [2:0] ep [8] = '{3'h1, 3'h0, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h0};

  always #5 clk_sys = ~clk_sys;

  // Minimum legal depth keeps the fill test short
  hrxf_top #(.DEPTH(128), .ADDR_W(16)) dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxWrEn(rxWrEn),
    .rxWrByte(rxWrByte), .rxWrPos(rxWrPos), .irq(irq));

  hrxf_framer_model fr_u (
    .clk_sys(clk_sys), .rxWrEn(rxWrEn), .rxWrByte(rxWrByte), .rxWrPos(rxWrPos));

  // ====
  // Tasks
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until ready is sampled high, then released
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask

  task automatic irqis(input logic x);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq}, {31'h0, x});
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ====
  // Main sequence
  initial begin
    logic [31:0] r;
    logic        e;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(ASTAT, 32'h0);
    rd(ALAT, 32'h0);
    rd(AEN, 32'h0);
    wr(AEN, 8'hff);
    rd(AEN, 32'h9d);
    wr(AEN, 8'h00);
    apb(1'b0, 16'h5448, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    wr(ACTL2, 8'h01);
    $display("test reset done");
    // Start byte with its enable off, reserved codes dropped
    fr_u.send(eb[0], ep[0]);
    fr_u.send(8'h3c, 3'h2);
    fr_u.send(8'h11, 3'h3);
    irqis(1'b0);
    rd(ALAT, 32'h08);
    wr(AEN, 8'h08);
    irqis(1'b1);
    wr(ALAT, 8'h08);
    irqis(1'b0);
    for (int i = 1; i < 8; i++) begin
      fr_u.send(eb[i], ep[i]);
    end
    repeat (3) @(posedge clk_sys);
    rd(ALAT, 32'h19);
    wr(AEN, 8'h01);
    irqis(1'b1);
    wr(AEN, 8'h00);
    irqis(1'b0);
    wr(ALAT, 8'hff);
    $display("test flags done");
    // Drain: status twice, reflects the next byte
    for (int i = 0; i < 8; i++) begin
      rd(ASTAT, {28'h0, ep[i], 1'b1});
      rd(ASTAT, {28'h0, ep[i], 1'b1});
      rd(ABYTE, {24'h0, eb[i]});
    end
    rd(ASTAT, 32'h0);
    $display("test drain done");
    // First received bit lands in bit 7 only when reordering
    wr(ACTL1, 8'h08);
    fr_u.send(8'h01, 3'h1);
    rd(ABYTE, 32'h80);
    wr(ACTL1, 8'h00);
    fr_u.send(8'h01, 3'h1);
    rd(ABYTE, 32'h01);
    // Inversion, then FIFO reset flushes and drops until a start
    wr(ACTL1, 8'h04);
    fr_u.send(8'h0f, 3'h1);
    rd(ABYTE, 32'hf0);
    fr_u.send(8'h21, 3'h1);
    wr(ACTL1, 8'h01);
    rd(ASTAT, 32'h0);
    wr(ACTL1, 8'h00);
    fr_u.send(8'h33, 3'h0);
    rd(ASTAT, 32'h0);
    fr_u.send(8'h44, 3'h1);
    rd(ASTAT, 32'h3);
    rd(ABYTE, 32'h44);
    wr(ALAT, 8'hff);
    $display("test reorder done");
    // Fill past full: avail, full and overflow flags
    for (int i = 0; i < 129; i++) begin
      fr_u.send(i[7:0], 3'h0);
    end
    repeat (3) @(posedge clk_sys);
    rd(ALAT, 32'h85);
    wr(AEN, 8'h04);
    irqis(1'b1);
    wr(ALAT, 8'h04);
    irqis(1'b0);
    rd(ASTAT, 32'h1);
    $display("test full done");
    stop_test();
  end
endmodule
